//--- core/bil_defs.vh
`ifndef BIL_DEFS_VH
`define BIL_DEFS_VH
// clock and timing
`define BIL_CLK_MHZ         100
`define BIL_RST_PHASE_US    15
`define BIL_RST_PHASE_CYC   (`BIL_RST_PHASE_US * `BIL_CLK_MHZ)
`define BIL_LINK_EN_NS      200
`define BIL_LINK_EN_CYC     ((`BIL_LINK_EN_NS * `BIL_CLK_MHZ) / 1000)
`define BIL_SPI_CORE_MHZ    400
`define BIL_SPI_DIV         160
`define BIL_SPI_HALF_CYC    ((`BIL_CLK_MHZ * `BIL_SPI_DIV) / (`BIL_SPI_CORE_MHZ * 2))
`define BIL_LINK_TX_HALF    4
// image and check values
`define BIL_CRC_POLY        32'hedb88320
`define BIL_CRC_SEED        32'hffffffff
`define BIL_CRC_BYPASS      32'h0d15ab1e
`define BIL_NULL_CHANEND    32'h0000ff02
`define BIL_END_TOKEN       8'h01
// spi command
`define BIL_SPI_READ_CMD    8'h03
`define BIL_SPI_START_ADDR  24'h000000
// memory bases
`define BIL_RAM_BASE        14'h0000
`define BIL_OTP_BASE        11'h000
// security register field
`define BIL_SEC_BOOT_BIT    5
// boot source codes reported on boot_source_out
`define BIL_SRC_NONE        3'h0
`define BIL_SRC_RESV        3'h1
`define BIL_SRC_LINK        3'h2
`define BIL_SRC_SPI         3'h3
`define BIL_SRC_OTP         3'h4
`endif

//--- core/bil_crc32.v
`timescale 1ns/1ps
// byte-serial reflected crc-32, one byte per clock
module bil_crc32 (
    input  wire        ref_clk_in,
    input  wire        reset_in,
    input  wire        init_in,
    input  wire        byte_valid_in,
    input  wire [7:0]  byte_in,
    output reg  [31:0] crc_out
);
`include "bil_defs.vh"

    reg [31:0] crc_next;
    integer    i;

    // eight reflected shift steps, low bit enters first
    always @* begin
        crc_next = crc_out ^ {24'h000000, byte_in};
        for (i = 0; i < 8; i = i + 1) begin
            if (crc_next[0]) begin
                crc_next = (crc_next >> 1) ^ `BIL_CRC_POLY;
            end else begin
                crc_next = crc_next >> 1;
            end
        end
    end

    // seeded with all ones at each new image
    always @(posedge ref_clk_in) begin
        if (reset_in || init_in) begin
            crc_out <= `BIL_CRC_SEED;
        end else if (byte_valid_in) begin
            crc_out <= crc_next;
        end
    end
endmodule

//--- core/bil_boot_loader.v
`timescale 1ns/1ps
// What this block does
// - all pin drivers stay off while chip reset is held
// - after reset an internal phase runs, then pulls enable and booting starts
// - the low two of three boot straps pick test-port wait, reserved, link b or spi
// - secure-boot bit set overrides the straps and boots from otp
// - image is length word, that many program words, then a check word
// - a check word equal to the bypass value skips crc checking
// - length and check words arrive least significant byte first
// - program loads from the lowest ram address and runs from there
// - reflected crc-32 over length and program, seeded ones, result inverted
// - spi master clock is core 400 mhz divided by 160
// - spi boot sends one read command and a 24-bit zero address
// - spi uses clock polarity 0 and phase 0
// - every spi data byte arrives least significant bit first
// - link b is enabled about 200 ns after boot starts
// - enabling link b drops pull-downs, drives outputs low, watches inputs
// - link boot: ack word, image, end token in, end token out, free, jump
// - secure boot reads the image from otp address zero
module bil_boot_loader #(
    parameter RAM_AW = 14,
    parameter OTP_AW = 11
) (
    input  wire              ref_clk_in,
    input  wire              reset_in,
    input  wire [2:0]        boot_src_strap_in,
    input  wire              pll_ratio_strap_lo_in,
    input  wire              pll_ratio_strap_hi_in,
    input  wire [31:0]       security_reg_in,
    input  wire              spi_miso_in,
    input  wire              link_b_in_wire0_in,
    input  wire              link_b_in_wire1_in,
    input  wire [31:0]       otp_data_in,
    input  wire              otp_valid_in,
    output reg               gpio_pull_en_out,
    output reg               link_b_pulldown_en_out,
    output reg  [1:0]        boot_clk_ratio_out,
    output reg  [2:0]        boot_source_out,
    output reg               spi_oe_out,
    output reg               spi_ss_n_out,
    output reg               spi_sclk_out,
    output reg               spi_mosi_out,
    output reg               link_b_out_oe_out,
    output reg               link_b_out_wire0_out,
    output reg               link_b_out_wire1_out,
    output reg               otp_rd_out,
    output reg  [OTP_AW-1:0] otp_addr_out,
    output reg               ram_we_out,
    output reg  [RAM_AW-1:0] ram_addr_out,
    output reg  [31:0]       ram_wdata_out,
    output reg               chanend0_busy_out,
    output reg               jump_out,
    output reg  [RAM_AW-1:0] jump_addr_out,
    output reg               boot_done_out,
    output reg               boot_fail_out
);
`include "bil_defs.vh"

    localparam S_RST       = 4'h0;
    localparam S_SEL       = 4'h1;
    localparam S_SPI_CMD   = 4'h2;
    localparam S_LINK_WAIT = 4'h3;
    localparam S_ACK       = 4'h4;
    localparam S_LOAD      = 4'h5;
    localparam S_END_IN    = 4'h6;
    localparam S_END_OUT   = 4'h7;
    localparam S_FREE      = 4'h8;
    localparam S_JUMP      = 4'h9;
    localparam S_HALT      = 4'ha;
    localparam S_FAIL      = 4'hb;
    localparam [7:0] SPI_CMD = `BIL_SPI_READ_CMD;

    reg  [3:0]  state_reg;
    reg  [15:0] cnt_reg;
    reg  [8:0]  sy1_reg;
    reg  [8:0]  sy2_reg;
    reg  [1:0]  field_reg;
    reg  [1:0]  bcnt_reg;
    reg  [31:0] acc_reg;
    reg  [31:0] words_left_reg;
    reg  [31:0] ack_reg;
    reg         tx_go_reg;
    wire        spi_active;
    wire        byte_v;
    wire [7:0]  byte_d;
    wire [31:0] word_in;
    wire [31:0] crc_val;
    wire        crc_en;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every pin input
    always @(posedge ref_clk_in) begin
        sy1_reg <= {security_reg_in[`BIL_SEC_BOOT_BIT], boot_src_strap_in,
                    pll_ratio_strap_hi_in, pll_ratio_strap_lo_in, spi_miso_in,
                    link_b_in_wire1_in, link_b_in_wire0_in};
        sy2_reg <= sy1_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // spi master engine, mode 0
    reg        spi_cmd_done_reg;
    reg [15:0] spi_div_reg;
    reg [31:0] spi_tx_reg;
    reg [4:0]  spi_txbits_reg;
    reg [7:0]  spi_rx_reg;
    reg [2:0]  spi_rxbits_reg;
    reg        spi_v_reg;
    reg [7:0]  spi_d_reg;

    assign spi_active = (state_reg == S_SPI_CMD) ||
                        (state_reg == S_LOAD && boot_source_out == `BIL_SRC_SPI);

    // sclk idles low, mosi changes on the falling edge, miso sampled rising
    always @(posedge ref_clk_in) begin
        spi_v_reg <= 1'b0;
        if (reset_in || !spi_active) begin
            spi_ss_n_out     <= 1'b1;
            spi_sclk_out     <= 1'b0;
            spi_mosi_out     <= 1'b0;
            spi_div_reg      <= 16'h0000;
            spi_cmd_done_reg <= 1'b0;
            spi_txbits_reg   <= 5'h00;
            spi_rxbits_reg   <= 3'h0;
            spi_tx_reg       <= 32'h00000000;
            spi_rx_reg       <= 8'h00;
            spi_d_reg        <= 8'h00;
        end else if (spi_ss_n_out) begin
            spi_ss_n_out <= 1'b0;
            spi_tx_reg   <= {`BIL_SPI_READ_CMD, `BIL_SPI_START_ADDR};
            spi_mosi_out <= SPI_CMD[7];
        end else if (spi_div_reg == `BIL_SPI_HALF_CYC - 1) begin
            spi_div_reg  <= 16'h0000;
            spi_sclk_out <= ~spi_sclk_out;
            if (!spi_sclk_out) begin
                if (spi_cmd_done_reg) begin
                    // first bit in is the byte's lowest
                    spi_rx_reg     <= {sy2_reg[2], spi_rx_reg[7:1]};
                    spi_rxbits_reg <= spi_rxbits_reg + 3'h1;
                    if (spi_rxbits_reg == 3'h7) begin
                        spi_v_reg <= 1'b1;
                        spi_d_reg <= {sy2_reg[2], spi_rx_reg[7:1]};
                    end
                end
            end else if (!spi_cmd_done_reg) begin
                spi_txbits_reg <= spi_txbits_reg + 5'h01;
                if (spi_txbits_reg == 5'h1f) begin
                    spi_cmd_done_reg <= 1'b1;
                    spi_mosi_out     <= 1'b0;
                end else begin
                    spi_tx_reg   <= {spi_tx_reg[30:0], 1'b0};
                    spi_mosi_out <= spi_tx_reg[30];
                end
            end
        end else begin
            spi_div_reg <= spi_div_reg + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link b receiver: 9-bit symbols, control flag first, data lsb first
    reg       l0_prev_reg;
    reg [8:0] lrx_sh_reg;
    reg [3:0] lrx_cnt_reg;
    reg       link_v_reg;
    reg       link_ctrl_reg;
    reg [7:0] link_d_reg;
    wire [8:0] lrx_next = {sy2_reg[1], lrx_sh_reg[8:1]};

    // inbound wire0 is sampled as the strobe, wire1 as data
    always @(posedge ref_clk_in) begin
        link_v_reg  <= 1'b0;
        l0_prev_reg <= sy2_reg[0];
        if (reset_in || !link_b_out_oe_out) begin
            lrx_sh_reg    <= 9'h000;
            lrx_cnt_reg   <= 4'h0;
            link_ctrl_reg <= 1'b0;
            link_d_reg    <= 8'h00;
        end else if (sy2_reg[0] && !l0_prev_reg) begin
            lrx_sh_reg <= lrx_next;
            if (lrx_cnt_reg == 4'h8) begin
                lrx_cnt_reg   <= 4'h0;
                link_v_reg    <= 1'b1;
                link_ctrl_reg <= lrx_next[0];
                link_d_reg    <= lrx_next[8:1];
            end else begin
                lrx_cnt_reg <= lrx_cnt_reg + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link b transmitter for the closing token; wires idle low
    reg       ltx_busy_reg;
    reg [8:0] ltx_sh_reg;
    reg [3:0] ltx_cnt_reg;
    reg [2:0] ltx_div_reg;

    always @(posedge ref_clk_in) begin
        if (reset_in || !link_b_out_oe_out) begin
            ltx_busy_reg         <= 1'b0;
            ltx_sh_reg           <= 9'h000;
            ltx_cnt_reg          <= 4'h0;
            ltx_div_reg          <= 3'h0;
            link_b_out_wire0_out <= 1'b0;
            link_b_out_wire1_out <= 1'b0;
        end else if (tx_go_reg) begin
            ltx_busy_reg         <= 1'b1;
            ltx_sh_reg           <= {1'b0, `BIL_END_TOKEN};
            link_b_out_wire1_out <= 1'b1; // control flag
            ltx_cnt_reg          <= 4'h0;
            ltx_div_reg          <= 3'h0;
        end else if (ltx_busy_reg) begin
            if (ltx_div_reg == `BIL_LINK_TX_HALF - 1) begin
                ltx_div_reg          <= 3'h0;
                link_b_out_wire0_out <= ~link_b_out_wire0_out;
                if (link_b_out_wire0_out) begin
                    ltx_cnt_reg <= ltx_cnt_reg + 4'h1;
                    if (ltx_cnt_reg == 4'h8) begin
                        ltx_busy_reg         <= 1'b0;
                        link_b_out_wire1_out <= 1'b0;
                    end else begin
                        link_b_out_wire1_out <= ltx_sh_reg[0];
                        ltx_sh_reg           <= ltx_sh_reg >> 1;
                    end
                end
            end else begin
                ltx_div_reg <= ltx_div_reg + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // otp fetch: one word per read, handed on as four bytes low first
    reg        otp_pend_reg;
    reg [2:0]  otp_left_reg;
    reg [31:0] otp_word_reg;
    reg        otp_v_reg;
    reg [7:0]  otp_d_reg;

    always @(posedge ref_clk_in) begin
        otp_rd_out <= 1'b0;
        otp_v_reg  <= 1'b0;
        if (reset_in || state_reg != S_LOAD || boot_source_out != `BIL_SRC_OTP) begin
            otp_addr_out <= `BIL_OTP_BASE;
            otp_pend_reg <= 1'b0;
            otp_left_reg <= 3'h0;
            otp_word_reg <= 32'h00000000;
            otp_d_reg    <= 8'h00;
        end else if (otp_left_reg != 3'h0) begin
            otp_v_reg    <= 1'b1;
            otp_d_reg    <= otp_word_reg[7:0];
            otp_word_reg <= otp_word_reg >> 8;
            otp_left_reg <= otp_left_reg - 3'h1;
        end else if (otp_pend_reg) begin
            if (otp_valid_in) begin
                otp_pend_reg <= 1'b0;
                otp_word_reg <= otp_data_in;
                otp_left_reg <= 3'h4;
                otp_addr_out <= otp_addr_out + 1'b1;
            end
        end else begin
            otp_rd_out   <= 1'b1;
            otp_pend_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // common byte stream; only the selected source is ever running
    assign byte_v  = spi_v_reg | otp_v_reg | (link_v_reg & ~link_ctrl_reg);
    assign byte_d  = spi_d_reg | otp_d_reg | (link_ctrl_reg ? 8'h00 : link_d_reg);
    assign word_in = {byte_d, acc_reg[31:8]};
    assign crc_en  = byte_v && state_reg == S_LOAD && field_reg != 2'h2;

    bil_crc32 u_crc (
        .ref_clk_in    (ref_clk_in),
        .reset_in      (reset_in),
        .init_in       (state_reg == S_SEL),
        .byte_valid_in (crc_en),
        .byte_in       (byte_d),
        .crc_out       (crc_val)
    );

    ////////////////////////////////////////////////////////////////////////
    // boot sequencer and image parser
    always @(posedge ref_clk_in) begin
        ram_we_out <= 1'b0;
        jump_out   <= 1'b0;
        tx_go_reg  <= 1'b0;
        if (reset_in) begin
            state_reg              <= S_RST;
            cnt_reg                <= 16'h0000;
            gpio_pull_en_out       <= 1'b0;
            link_b_pulldown_en_out <= 1'b0;
            spi_oe_out             <= 1'b0;
            link_b_out_oe_out      <= 1'b0;
            boot_clk_ratio_out     <= 2'h0;
            boot_source_out        <= `BIL_SRC_NONE;
            ram_addr_out           <= `BIL_RAM_BASE;
            ram_wdata_out          <= 32'h00000000;
            chanend0_busy_out      <= 1'b0;
            jump_addr_out          <= `BIL_RAM_BASE;
            boot_done_out          <= 1'b0;
            boot_fail_out          <= 1'b0;
            field_reg              <= 2'h0;
            bcnt_reg               <= 2'h0;
            acc_reg                <= 32'h00000000;
            words_left_reg         <= 32'h00000000;
            ack_reg                <= 32'h00000000;
        end else begin
            case (state_reg)
                S_RST: begin
                    // pll ratio straps are looked at once, at the end of this phase; boot straps and secure bit once, the cycle after in S_SEL
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == `BIL_RST_PHASE_CYC - 1) begin
                        cnt_reg                <= 16'h0000;
                        gpio_pull_en_out       <= 1'b1;
                        link_b_pulldown_en_out <= 1'b1;
                        boot_clk_ratio_out     <= sy2_reg[4:3];
                        state_reg              <= S_SEL;
                    end
                end
                S_SEL: begin
                    field_reg <= 2'h0;
                    bcnt_reg  <= 2'h0;
                    if (sy2_reg[8]) begin
                        boot_source_out <= `BIL_SRC_OTP;
                        state_reg       <= S_LOAD;
                    end else begin
                        case (sy2_reg[6:5])
                            2'h2: begin
                                boot_source_out <= `BIL_SRC_LINK;
                                state_reg       <= S_LINK_WAIT;
                            end
                            2'h3: begin
                                boot_source_out <= `BIL_SRC_SPI;
                                spi_oe_out      <= 1'b1;
                                state_reg       <= S_SPI_CMD;
                            end
                            2'h1: begin
                                boot_source_out <= `BIL_SRC_RESV;
                                state_reg       <= S_HALT;
                            end
                            default: state_reg <= S_HALT;
                        endcase
                    end
                end
                S_SPI_CMD: begin
                    if (spi_cmd_done_reg) begin
                        state_reg <= S_LOAD;
                    end
                end
                S_LINK_WAIT: begin
                    cnt_reg <= cnt_reg + 16'h0001;
                    if (cnt_reg == `BIL_LINK_EN_CYC - 1) begin
                        link_b_pulldown_en_out <= 1'b0;
                        link_b_out_oe_out      <= 1'b1;
                        chanend0_busy_out      <= 1'b1;
                        state_reg              <= S_ACK;
                    end
                end
                S_ACK: begin
                    if (byte_v) begin
                        acc_reg  <= word_in;
                        bcnt_reg <= bcnt_reg + 2'h1;
                        if (bcnt_reg == 2'h3) begin
                            ack_reg   <= word_in;
                            state_reg <= S_LOAD;
                        end
                    end
                end
                S_LOAD: begin
                    if (byte_v) begin
                        acc_reg  <= word_in;
                        bcnt_reg <= bcnt_reg + 2'h1;
                        if (bcnt_reg == 2'h3) begin
                            case (field_reg)
                                2'h0: begin
                                    words_left_reg <= word_in;
                                    field_reg <= (word_in == 32'h0) ? 2'h2 : 2'h1;
                                end
                                2'h1: begin
                                    ram_we_out     <= 1'b1;
                                    ram_wdata_out  <= word_in;
                                    words_left_reg <= words_left_reg - 32'h1;
                                    if (words_left_reg == 32'h1) begin
                                        field_reg <= 2'h2;
                                    end
                                end
                                default: begin
                                    if (word_in == `BIL_CRC_BYPASS ||
                                        word_in == ~crc_val) begin
                                        state_reg <= (boot_source_out == `BIL_SRC_LINK)
                                                     ? S_END_IN : S_JUMP;
                                    end else begin
                                        state_reg <= S_FAIL;
                                    end
                                end
                            endcase
                        end
                    end
                    // address advances after each written word
                    if (ram_we_out) begin
                        ram_addr_out <= ram_addr_out + 1'b1;
                    end
                end
                S_END_IN: begin
                    if (link_v_reg && link_ctrl_reg && link_d_reg == `BIL_END_TOKEN) begin
                        // a null channel end means no token goes back
                        if (ack_reg == `BIL_NULL_CHANEND) begin
                            state_reg <= S_FREE;
                        end else begin
                            tx_go_reg <= 1'b1;
                            state_reg <= S_END_OUT;
                        end
                    end
                end
                S_END_OUT: begin
                    if (!tx_go_reg && !ltx_busy_reg) begin
                        state_reg <= S_FREE;
                    end
                end
                S_FREE: begin
                    chanend0_busy_out <= 1'b0;
                    state_reg         <= S_JUMP;
                end
                S_JUMP: begin
                    jump_out      <= 1'b1;
                    jump_addr_out <= `BIL_RAM_BASE;
                    boot_done_out <= 1'b1;
                    spi_oe_out    <= 1'b0;
                    state_reg     <= S_HALT;
                end
                S_FAIL: begin
                    boot_fail_out <= 1'b1;
                    spi_oe_out    <= 1'b0;
                    state_reg     <= S_HALT;
                end
                S_HALT: begin
                    state_reg <= S_HALT;
                end
                default: state_reg <= S_RST;
            endcase
        end
    end
endmodule

//--- verif/bil_boot_loader_monitor.sv
`timescale 1ns/1ps
// pin-level watch on the boot loader
module bil_boot_loader_monitor (
    input wire        ref_clk_in, reset_in, gpio_pull_en_out, spi_oe_out,
    input wire        spi_ss_n_out, spi_sclk_out, spi_mosi_out, ram_we_out,
    input wire [13:0] ram_addr_out, jump_addr_out,
    input wire        jump_out, boot_done_out, boot_fail_out
);
    reg [13:0] wr_reg;
    reg [11:0] up_reg;
    // writes so far; cycles since release, held at the top so it cannot wrap
    always @(posedge ref_clk_in) begin
        wr_reg <= reset_in ? 14'h0 : wr_reg + {13'h0, ram_we_out};
        up_reg <= reset_in ? 12'h0 : up_reg + {11'h0, up_reg != 12'hfff};
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_jump_zero; (jump_addr_out == 14'h0) ##1 (!jump_out && boot_done_out); endsequence
    a_reset_pins_off: assert property (disable iff (1'b0) reset_in |-> ##1
        !spi_oe_out && !gpio_pull_en_out) else $error("pins on in reset");
    a_pull_time: assert property ($rose(gpio_pull_en_out) |->
        up_reg >= 12'h5db && up_reg <= 12'h5de) else $error("pulls mistimed");
    a_select_start: assert property ($fell(spi_ss_n_out) |->
        !spi_sclk_out && !spi_mosi_out) else $error("bad select start");
    // the last half period is cut short when the frame ends and select rises
    a_sclk_half: assert property ($rose(spi_sclk_out) |-> ##20
        ($fell(spi_sclk_out) || spi_ss_n_out))
        else $error("sclk period");
    a_spi_driven: assert property (!spi_ss_n_out |-> spi_oe_out)
        else $error("spi pins off");
    a_ram_order: assert property (ram_we_out |-> ram_addr_out == wr_reg)
        else $error("ram address");
    a_jump_zero: assert property (jump_out |-> s_jump_zero)
        else $error("bad jump");
    a_fail_no_jump: assert property (boot_fail_out |-> !jump_out)
        else $error("jump after fail");
endmodule

//--- verif/bil_flash_model.sv
`timescale 1ns/1ps
// spi flash stand-in, mode 0: data changes on falling edges
module bil_flash_model (
    input  wire ss_n_in,
    input  wire sclk_in,
    output reg  miso_out
);
    reg [31:0] img [0:3];
    integer    n = 0;
    // two words, bypass check word; bytes low first, bits lsb first
    initial begin
        img[0] = 32'h2;
        img[1] = 32'h11223344;
        img[2] = 32'hcafef00d;
        img[3] = 32'h0d15ab1e;
        miso_out = 1'b0;
    end
    // command clocks pass unanswered; deselected, the line inverts instead of holding
    always @(negedge sclk_in or posedge ss_n_in) begin
        if (ss_n_in) miso_out <= ~miso_out;
        else if (n >= 31) miso_out <= img[(n - 31) / 32][(n - 31) % 32];
        n <= ss_n_in ? 0 : n + 1;
    end
endmodule

//--- verif/testbench.sv
`timescale 1ns/1ps
bind bil_boot_loader bil_boot_loader_monitor u_mon (.*);
module testbench;
    reg         clk = 1'b0, rst = 1'b1, ov = 1'b0;
    reg  [2:0]  strap = 3'h0;
    reg  [31:0] sec = 32'h0, od = 32'h0, jumps = 32'h0, oimg [0:3], mem [0:3];
    reg         lw0 = 1'b0, lw1 = 1'b0, lo_prev = 1'b0;
    reg  [31:0] ltx = 32'h0;
    integer     mismatches = 0, comparisons = 0, i, n, k, j;
    wire        miso, ss_n, sclk, ord, we, jmp, done, fail, lo, busy;
    wire [2:0]  src;
    wire [10:0] oa;
    wire [13:0] ra;
    wire [31:0] rd;
    bil_boot_loader u_dut (.ref_clk_in(clk), .reset_in(rst), .boot_src_strap_in(strap),
        .pll_ratio_strap_lo_in(1'b1), .pll_ratio_strap_hi_in(1'b0), .security_reg_in(sec),
        .spi_miso_in(miso), .link_b_in_wire0_in(lw0), .link_b_in_wire1_in(lw1),
        .otp_data_in(od), .otp_valid_in(ov), .gpio_pull_en_out(), .link_b_pulldown_en_out(),
        .boot_clk_ratio_out(), .boot_source_out(src), .spi_oe_out(), .spi_ss_n_out(ss_n),
        .spi_sclk_out(sclk), .spi_mosi_out(), .link_b_out_oe_out(), .link_b_out_wire0_out(lo),
        .link_b_out_wire1_out(), .otp_rd_out(ord), .otp_addr_out(oa), .ram_we_out(we),
        .ram_addr_out(ra), .ram_wdata_out(rd), .chanend0_busy_out(busy), .jump_out(jmp),
        .jump_addr_out(), .boot_done_out(done), .boot_fail_out(fail));
    bil_flash_model u_flash (.ss_n_in(ss_n), .sclk_in(sclk), .miso_out(miso));
    // 100 mhz clock
    initial forever #5 clk = ~clk;
    // otp answers the cycle after a read; ram writes and jumps are logged
    always @(posedge clk) begin
        ov <= ord === 1'b1;
        od <= oimg[oa[1:0]];
        if (we === 1'b1) mem[ra[1:0]] <= rd;
        jumps <= rst ? 32'h0 : jumps + {31'h0, jmp === 1'b1};
        // strobe edges of the reply token
        lo_prev <= lo;
        ltx <= rst ? 32'h0 : ltx + {31'h0, lo === 1'b1 && lo_prev !== 1'b1};
    end
    // one link symbol: flag first, then data lsb first on wire1, strobed by wire0
    task sym(input [8:0] s);
        for (k = 0; k < 9; k = k + 1) begin
            lw1 <= s[k];
            repeat (4) @(posedge clk);
            lw0 <= 1'b1;
            repeat (4) @(posedge clk);
            lw0 <= 1'b0;
        end
    endtask
    task lword(input [31:0] w);
        for (j = 0; j < 4; j = j + 1) sym({w[8*j +: 8], 1'b0});
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) mismatches = mismatches + 1;
        if (got !== exp) $display("[ERR] %0t got %h want %h", $time, got, exp);
    endtask
    // straps are set with reset and left alone; boot ends on done, fail or a limit
    task boot(input [2:0] s, input [31:0] sb);
        @(posedge clk) rst <= 1'b1;
        strap <= s;
        sec <= sb;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (1510) @(posedge clk);
        for (n = 0; n < 9000 && done !== 1'b1 && fail !== 1'b1; n = n + 1) @(posedge clk);
        @(posedge clk);
    endtask
    task finish_test;
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // hang guard, well past the expected 33k cycles
    initial #500000 begin mismatches = mismatches + 1; finish_test; end
    // halting straps, spi boot with bypass, link boot, then secure otp boot with a bad check word
    initial begin
        for (i = 0; i < 2; i = i + 1) begin
            boot(i[2:0], 32'h0);
            chk({29'h0, src}, i);
        end
        boot(3'h3, 32'h0);
        chk({29'h0, src}, 32'h3);
        chk(mem[0], 32'h11223344);
        chk(mem[1], 32'hcafef00d);
        chk(jumps, 32'h1);
        // link boot; wires stay low until the link is enabled
        fork
            boot(3'h2, 32'h0);
            begin
                repeat (1545) @(posedge clk);
                lword(32'h00000102);
                lword(32'h1);
                lword(32'h89abcdef);
                lword(32'h0d15ab1e);
                sym({8'h01, 1'b1});
            end
        join
        chk({29'h0, src}, 32'h2);
        chk(mem[0], 32'h89abcdef);
        chk(ltx, 32'h9);
        chk({31'h0, busy}, 32'h0);
        chk(jumps, 32'h1);
        oimg[0] = 32'h1;
        oimg[1] = 32'h5a0f3cc3;
        oimg[2] = 32'h0;
        boot(3'h3, 32'h20);
        chk({29'h0, src}, 32'h4);
        chk(mem[0], 32'h5a0f3cc3);
        chk({31'h0, fail}, 32'h1);
        chk(jumps, 32'h0);
        finish_test;
    end
endmodule
